// [core/gpio_int_pkg.sv]
package gpio_int_pkg;

   // ****************************************************************
   // Register map (byte addresses, one aligned word each)
   // ****************************************************************
   localparam logic [7:0] ADDR_PORT_DATA   = 8'h00;
   localparam logic [7:0] ADDR_INT_ENABLE  = 8'h04;
   localparam logic [7:0] ADDR_MODE_LO     = 8'h08;
   localparam logic [7:0] ADDR_MODE_HI     = 8'h0C;
   localparam logic [7:0] ADDR_DRIVE_MODE0 = 8'h10;
   localparam logic [7:0] ADDR_DRIVE_MODE1 = 8'h14;
   localparam logic [7:0] ADDR_DRIVE_MODE2 = 8'h18;
   localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_MASK    = 8'h20;
   localparam logic [7:0] ADDR_PIN_LEVEL   = 8'h24;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0] RST_PORT_DATA   = 8'h00;
   localparam logic [7:0] RST_INT_ENABLE  = 8'h00;
   localparam logic [7:0] RST_MODE        = 8'h00;
   localparam logic [7:0] RST_DRIVE_MODE0 = 8'h00;
   localparam logic [7:0] RST_DRIVE_MODE1 = 8'hFF;
   localparam logic [7:0] RST_DRIVE_MODE2 = 8'hFF;
   localparam logic [7:0] RST_IRQ_MASK    = 8'h00;
   localparam logic [1:0] RST_IRQ_STATUS  = 2'h0;
   localparam logic [7:0] RST_LATCH       = 8'h00;

   // ****************************************************************
   // Encodings
   // ****************************************************************
   localparam logic [1:0] MODE_DISABLED = 2'h0;
   localparam logic [1:0] MODE_LOW      = 2'h1;
   localparam logic [1:0] MODE_HIGH     = 2'h2;
   localparam logic [1:0] MODE_CHANGE   = 2'h3;
   localparam logic [2:0] DRIVE_ANALOG_HIZ = 3'h6;

   // Status bit positions
   localparam int STAT_PORT_IRQ  = 0;
   localparam int STAT_READ_DONE = 1;

endpackage : gpio_int_pkg

// [core/gpio_pin_interrupt_mode.sv]
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_interrupt_mode
   import gpio_int_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic                  pready,
   output logic [31:0]           prdata,
   output logic                  pslverr,
   input  wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0]      pinIntLine,
   output logic                  portIntReq,
   output logic                  irq
);

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [WIDTH-1:0] intEnable_q;
   logic [WIDTH-1:0] modeLo_q;
   logic [WIDTH-1:0] modeHi_q;
   logic [WIDTH-1:0] drive0_q;
   logic [WIDTH-1:0] drive1_q;
   logic [WIDTH-1:0] drive2_q;
   logic [WIDTH-1:0] readLatch_q;
   logic [1:0]       status_q;
   logic [1:0]       mask_q;
   logic [WIDTH-1:0] pinReq;
   logic [WIDTH-1:0] digIn;
   logic             portReq;
   logic             portReqPrev_q;

   // Bus strobes, decoded once and shared by every register process
   logic             access;
   logic             xferDone;
   logic             wrEn;
   logic             rdEn;
   logic             dataRead;
   logic             irqClr;
   logic             readClr;
   logic [31:0]      rdData_d;

   // Address decode used by the write enable and the slave error
   function automatic logic isMapped(input logic [7:0] a);
      case (a)
         ADDR_PORT_DATA, ADDR_INT_ENABLE, ADDR_MODE_LO, ADDR_MODE_HI,
         ADDR_DRIVE_MODE0, ADDR_DRIVE_MODE1, ADDR_DRIVE_MODE2,
         ADDR_IRQ_STATUS, ADDR_IRQ_MASK, ADDR_PIN_LEVEL: isMapped = 1'b1;
         default: isMapped = 1'b0;
      endcase
   endfunction : isMapped

   // Analog high-Z turns the digital input buffer off, so the pin reads 0
   function automatic logic isAnalog(input logic [2:0] dm);
      isAnalog = (dm == DRIVE_ANALOG_HIZ);
   endfunction : isAnalog

   // Write-one-to-clear hit on the status register for one bit
   function automatic logic isStatClr(input logic       we,
                                      input logic [7:0] a,
                                      input logic       wBit);
      isStatClr = we & (a == ADDR_IRQ_STATUS) & wBit;
   endfunction : isStatClr

   // ****************************************************************
   // APB access: one wait state, answered in the access phase
   // ****************************************************************
   // The first access edge, with pready still low, launches pready and
   // the read data. Writes wait for the completing edge, where the master
   // samples pready high, so a register changes exactly when the master
   // sees the transfer end.
   assign access   = psel & penable & ~pready;
   assign xferDone = psel & penable & pready;
   assign wrEn     = xferDone & pwrite & isMapped(paddr);
   assign rdEn     = access & ~pwrite;
   assign dataRead = rdEn & (paddr == ADDR_PORT_DATA);

   // Write-one clears, decoded once per status bit
   assign irqClr  = isStatClr(wrEn, paddr, pwdata[STAT_PORT_IRQ]);
   assign readClr = isStatClr(wrEn, paddr, pwdata[STAT_READ_DONE]);

   // pready as a one-cycle flop pulse: one wait state always, and every
   // output stays a flop
   always_ff @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
      end else begin
         pready <= access;
      end
   end

   // Unmapped offsets answer with an error alongside pready
   always_ff @(posedge clk) begin
      if (rst) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= access & ~isMapped(paddr);
      end
   end

   // ****************************************************************
   // Per-pin cells
   // ****************************************************************
   // One cell per pin; the cell owns the mode decode
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : gPin
         logic [1:0] pinMode;
         logic [2:0] pinDm;
         // The same bit of each plane forms the pin's mode fields
         assign pinMode = {modeHi_q[g], modeLo_q[g]};
         assign pinDm   = {drive2_q[g], drive1_q[g], drive0_q[g]};
         pin_int_cell uCell (
            .pinIn        (pinIn[g]),
            .pinIntMode   (pinMode),
            .intEnable    (intEnable_q[g]),
            .readLatch    (readLatch_q[g]),
            .pinDriveMode (pinDm),
            .pinIntReq    (pinReq[g])
         );
         // Same input view the cell uses, for the data register read
         assign digIn[g] = isAnalog(pinDm) ? 1'b0 : pinIn[g];
      end
   endgenerate

   // Any pin request raises the port request, as a level
   assign portReq = |pinReq;

   // ****************************************************************
   // Software registers, one process per register group
   // ****************************************************************
   // Data register writes are accepted and dropped: this block has no
   // output driver, and a read of the data register returns the pin
   // view, so a stored value would never be seen.

   // Interrupt mode bit planes; mode 00 after reset keeps every pin
   // quiet even with its enable set
   always_ff @(posedge clk) begin
      if (rst) begin
         modeLo_q <= RST_MODE;
         modeHi_q <= RST_MODE;
      end else if (wrEn) begin
         if (paddr == ADDR_MODE_LO) begin
            modeLo_q <= pwdata[WIDTH-1:0];
         end
         if (paddr == ADDR_MODE_HI) begin
            modeHi_q <= pwdata[WIDTH-1:0];
         end
      end
   end

   // Per-pin interrupt enables; a cleared bit holds the pin line low
   // rather than floating it
   always_ff @(posedge clk) begin
      if (rst) begin
         intEnable_q <= RST_INT_ENABLE;
      end else if (wrEn && paddr == ADDR_INT_ENABLE) begin
         intEnable_q <= pwdata[WIDTH-1:0];
      end
   end

   // Drive mode bit planes. Reset leaves every pin analog high-Z, reading 0,
   // so a pin in low-level mode with its enable set still interrupts.
   always_ff @(posedge clk) begin
      if (rst) begin
         drive0_q <= RST_DRIVE_MODE0;
         drive1_q <= RST_DRIVE_MODE1;
         drive2_q <= RST_DRIVE_MODE2;
      end else if (wrEn) begin
         if (paddr == ADDR_DRIVE_MODE0) begin
            drive0_q <= pwdata[WIDTH-1:0];
         end
         if (paddr == ADDR_DRIVE_MODE1) begin
            drive1_q <= pwdata[WIDTH-1:0];
         end
         if (paddr == ADDR_DRIVE_MODE2) begin
            drive2_q <= pwdata[WIDTH-1:0];
         end
      end
   end

   // Interrupt mask, laid out like the status register
   always_ff @(posedge clk) begin
      if (rst) begin
         mask_q <= RST_IRQ_MASK[1:0];
      end else if (wrEn && paddr == ADDR_IRQ_MASK) begin
         mask_q <= pwdata[1:0];
      end
   end

   // Read latch: captures the pin view the CPU actually saw. Change mode
   // compares against it, so software that skips the data read on a
   // service gets a plain level interrupt instead of a change.
   always_ff @(posedge clk) begin
      if (rst) begin
         readLatch_q <= RST_LATCH;
      end else if (dataRead) begin
         readLatch_q <= digIn;
      end
   end

   // ****************************************************************
   // Sticky status: set wins over a write-one clear in the same cycle
   // ****************************************************************
   // Edge memory of the merged request: a level held high sets bit 0
   // once, not on every cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         portReqPrev_q <= 1'b0;
      end else begin
         portReqPrev_q <= portReq;
      end
   end

   // Both sticky bits; a clear only removes what no new event sets
   always_ff @(posedge clk) begin
      if (rst) begin
         status_q <= RST_IRQ_STATUS;
      end else begin
         status_q[STAT_PORT_IRQ]  <= (portReq & ~portReqPrev_q) |
                                     (status_q[STAT_PORT_IRQ] & ~irqClr);
         status_q[STAT_READ_DONE] <= dataRead |
                                     (status_q[STAT_READ_DONE] & ~readClr);
      end
   end

   // ****************************************************************
   // Outputs, all registered
   // ****************************************************************
   // Per-pin lines, one clock behind their cause
   always_ff @(posedge clk) begin
      if (rst) begin
         pinIntLine <= '0;
      end else begin
         pinIntLine <= pinReq;
      end
   end

   // Merged port request toward the interrupt controller
   always_ff @(posedge clk) begin
      if (rst) begin
         portIntReq <= 1'b0;
      end else begin
         portIntReq <= portReq;
      end
   end

   // Level interrupt while any unmasked sticky bit stands; software
   // clears the status bit; a port request still held does not set it again
   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_q & mask_q);
      end
   end

   // Read mux; the data register returns the pin view.
   // Unused bits and unmapped offsets read as zero.
   always_comb begin
      rdData_d = 32'h0000_0000;
      case (paddr)
         ADDR_PORT_DATA:   rdData_d[WIDTH-1:0] = digIn;
         ADDR_INT_ENABLE:  rdData_d[WIDTH-1:0] = intEnable_q;
         ADDR_MODE_LO:     rdData_d[WIDTH-1:0] = modeLo_q;
         ADDR_MODE_HI:     rdData_d[WIDTH-1:0] = modeHi_q;
         ADDR_DRIVE_MODE0: rdData_d[WIDTH-1:0] = drive0_q;
         ADDR_DRIVE_MODE1: rdData_d[WIDTH-1:0] = drive1_q;
         ADDR_DRIVE_MODE2: rdData_d[WIDTH-1:0] = drive2_q;
         ADDR_IRQ_STATUS:  rdData_d[1:0]       = status_q;
         ADDR_IRQ_MASK:    rdData_d[1:0]       = mask_q;
         ADDR_PIN_LEVEL:   rdData_d[WIDTH-1:0] = readLatch_q;
         default:          rdData_d            = 32'h0000_0000;
      endcase
   end

   // Read data launched with pready and held until the next read
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (rdEn) begin
         prdata <= rdData_d;
      end
   end

endmodule : gpio_pin_interrupt_mode

`default_nettype wire

// [core/pin_int_cell.sv]
`timescale 1ns/1ps
`default_nettype none

module pin_int_cell
   import gpio_int_pkg::*;
(
   input  wire logic       pinIn,
   input  wire logic [1:0] pinIntMode,
   input  wire logic       intEnable,
   input  wire logic       readLatch,
   input  wire logic [2:0] pinDriveMode,
   output logic            pinIntReq
);

   logic digIn;

   // Analog high-Z shuts the input buffer off to save crowbar current
   assign digIn = (pinDriveMode == DRIVE_ANALOG_HIZ) ? 1'b0 : pinIn;

   // Mode decode, gated by the per-pin enable
   always_comb begin
      case (pinIntMode)
         MODE_DISABLED: pinIntReq = 1'b0;
         MODE_LOW:      pinIntReq = intEnable & ~digIn;
         MODE_HIGH:     pinIntReq = intEnable & digIn;
         MODE_CHANGE:   pinIntReq = intEnable & (digIn ^ readLatch);
         default:       pinIntReq = 1'b0;
      endcase
   end

endmodule : pin_int_cell

`default_nettype wire

// [sim/gpio_pin_interrupt_mode_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_interrupt_mode_bench
   import gpio_int_pkg::*;
;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00, np = 8'h00, pins, lo, hi, en, dm, lat, v;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [7:0]  pinIntLine;
   logic        pready, pslverr, portIntReq, irq;
   logic [32:0] expq [$];
   int          error_cnt = 0, total_checks = 0;
   logic [7:0]  rv [10] = '{RST_PORT_DATA, RST_INT_ENABLE, RST_MODE, RST_MODE, RST_DRIVE_MODE0,
                            RST_DRIVE_MODE1, RST_DRIVE_MODE2, 8'h00, RST_IRQ_MASK, RST_LATCH};
   pin_partner_model pm (.clk(clk), .nextPins(np), .pins(pins));
   gpio_pin_interrupt_mode #(.WIDTH(8)) dut (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .pinIn(pins), .pinIntLine(pinIntLine),
      .portIntReq(portIntReq), .irq(irq));
   always #25 clk = ~clk;
   task automatic check(input logic [32:0] s, input logic [32:0] e);
      total_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : check
   task automatic finish_test();
      $display("Checks %0d, errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : finish_test
   // Request held until pready is sampled high; reads leave a note
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      if (!w) expq.push_back(e);
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   function automatic logic [7:0] f(input logic [7:0] l);
      return en & (~hi & lo & ~v | hi & ~lo & v | hi & lo & (v ^ l));
   endfunction : f
   // Each read answer is matched with the oldest note
   always @(posedge clk) begin
      if (psel && penable && pready && !pwrite) check({pslverr, prdata}, expq.pop_front());
   end
   // Watchdog sized well beyond the expected run
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      finish_test();
   end
   initial begin
      void'($urandom(32'h84EF));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 1; i < 10; i++) apb(0, 8'(i * 4), 0, {25'h0, rv[i]});
      apb(1, 8'h40, 32'hFF, 0);
      apb(0, 8'h40, 0, {1'b1, 32'h0});
      // First four passes set one mode on every pin, the rest mix them
      for (int j = 0; j < 16; j++) begin
         lo = (j < 4) ? {8{j[0]}} : 8'($urandom);
         hi = (j < 4) ? {8{j[1]}} : 8'($urandom);
         en = 8'($urandom);
         dm = (j < 4) ? 8'h00 : 8'($urandom);
         apb(1, ADDR_MODE_LO, {24'h0, lo}, 0);
         apb(1, ADDR_MODE_HI, {24'h0, hi}, 0);
         apb(1, ADDR_INT_ENABLE, {24'h0, en}, 0);
         apb(1, ADDR_DRIVE_MODE2, {24'h0, dm}, 0);
         np <= 8'($urandom);
         repeat (2) @(posedge clk);
         lat = np & ~dm;
         apb(0, ADDR_PORT_DATA, 0, {25'h0, lat});
         apb(0, ADDR_PIN_LEVEL, 0, {25'h0, lat});
         np <= 8'($urandom);
         repeat (3) @(posedge clk);
         v = np & ~dm;
         check({25'h0, pinIntLine}, {25'h0, f(lat)});
         check({32'h0, portIntReq}, {32'h0, |f(lat)});
         apb(0, ADDR_PORT_DATA, 0, {25'h0, v});
         repeat (3) @(posedge clk);
         check({25'h0, pinIntLine}, {25'h0, f(v)});
      end
      // Read-done status raised, masked, unmasked and cleared
      apb(1, ADDR_IRQ_MASK, 32'h2, 0);
      repeat (2) @(posedge clk);
      check({32'h0, irq}, 33'h1);
      apb(1, ADDR_IRQ_MASK, 32'h0, 0);
      repeat (2) @(posedge clk);
      check({32'h0, irq}, 33'h0);
      apb(1, ADDR_IRQ_MASK, 32'h2, 0);
      apb(1, ADDR_IRQ_STATUS, 32'h3, 0);
      repeat (2) @(posedge clk);
      check({32'h0, irq}, 33'h0);
      apb(0, ADDR_IRQ_STATUS, 0, 33'h0);
      finish_test();
   end
endmodule : gpio_pin_interrupt_mode_bench
`default_nettype wire

// [sim/gpio_pin_interrupt_mode_props.sv]
`timescale 1ns/1ps
`default_nettype none
// *****
// Port checker
// *****
module gpio_pin_interrupt_mode_props
   import gpio_int_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire logic             clk,
   input wire logic             rst,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pwrite,
   input wire logic [7:0]       paddr,
   input wire logic [31:0]      pwdata,
   input wire logic             pready,
   input wire logic [31:0]      prdata,
   input wire logic             pslverr,
   input wire logic [WIDTH-1:0] pinIn,
   input wire logic [WIDTH-1:0] pinIntLine,
   input wire logic             portIntReq,
   input wire logic             irq
);
   logic [WIDTH-1:0] sh [10];
   logic [WIDTH-1:0] latchSh, an, vw, expD, expQ, chgQ;
   logic             done;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Shadow registers follow accepted transfers only
   assign done = psel && penable && pready && !pslverr;
   assign an   = sh[6] & sh[5] & ~sh[4];
   assign vw   = pinIn & ~an;
   assign expD = sh[1] & (~sh[3] & sh[2] & ~vw | sh[3] & ~sh[2] & vw
                 | sh[3] & sh[2] & (vw ^ latchSh));
   always_ff @(posedge clk) begin
      if (rst) begin
         foreach (sh[i]) sh[i] <= '0;
         sh[5]   <= RST_DRIVE_MODE1;
         sh[6]   <= RST_DRIVE_MODE2;
         latchSh <= RST_LATCH;
         expQ    <= '0;
         chgQ    <= '0;
      end else begin
         if (done && pwrite) sh[paddr[5:2]] <= pwdata[WIDTH-1:0];
         if (done && !pwrite && paddr == ADDR_PORT_DATA) latchSh <= prdata[WIDTH-1:0];
         expQ <= expD;
         chgQ <= sh[2] & sh[3];
      end
   end
   sequence sAccess; psel && penable && !pready; endsequence
   sequence sAnswer; pready; endsequence
   sequence sRd; psel && penable && pready && !pwrite; endsequence
   AST_WAIT_ONE: assert property (sAccess |=> sAnswer)
      else $error("answer late");
   AST_READY_PULSE: assert property (sAnswer |=> !pready)
      else $error("ready too long");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("stray slave error");
   AST_LEVEL_MODES: assert property (((pinIntLine ^ expQ) & ~chgQ) == '0)
      else $error("level mode line wrong");
   AST_CHANGE_MODE: assert property (!$past(psel) |-> ((pinIntLine ^ expQ) & chgQ) == '0)
      else $error("change mode line wrong");
   AST_PORT_OR: assert property (portIntReq == |pinIntLine)
      else $error("port request not merged");
   AST_LATCH_READ: assert property (sRd ##0 paddr == ADDR_PIN_LEVEL
      |-> prdata[WIDTH-1:0] == latchSh)
      else $error("read latch wrong");
   AST_ANALOG_ZERO: assert property (sRd ##0 paddr == ADDR_PORT_DATA
      |-> (prdata[WIDTH-1:0] & an) == '0)
      else $error("analog pin not zero");
   AST_IRQ_MASKED: assert property (sh[8][1:0] == 2'h0 |=> !irq)
      else $error("masked irq seen");
endmodule : gpio_pin_interrupt_mode_props
bind gpio_pin_interrupt_mode gpio_pin_interrupt_mode_props #(.WIDTH(WIDTH)) chk (
   .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .pinIn(pinIn), .pinIntLine(pinIntLine), .portIntReq(portIntReq), .irq(irq));
`default_nettype wire

// [sim/pin_partner_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_partner_model (
   input  wire logic       clk,
   input  wire logic [7:0] nextPins,
   output logic      [7:0] pins
);
   // Pins move one clock after a request, at the next rising edge
   initial pins = 8'h00;
   always @(posedge clk) pins <= nextPins;
endmodule : pin_partner_model
`default_nettype wire
